// file: rtl/pef_event_flags.sv
// Event flags, masks, interrupt pin and serial register access
//
// How it works
// - A too-low supply for storing defaults latches flag bit 5 of the first flag register.
// - Every rising or falling edge of the mains-detect input latches flag bit 4 of the first flag register.
// - Every level change of the push-button input latches flag bit 3 of the first flag register.
// - Bit 2 of the first flag register follows the overheat warning level, 1 above and 0 below the threshold.
// - Completion of the default store latches flag bit 0 of the first flag register.
// - A load switch over-temperature shutdown latches flag bit 5 of the second flag register.
// - Bit 2 of the second flag register reads 1 exactly while the load switch limits current.
// - A mask bit of 0 lets its event pull the interrupt pin low, a mask bit of 1 hides it from the pin.
// - Flags record events whatever the masks say; masks only gate the interrupt pin.
// - The first mask register keeps its masks at bits 5, 4, 3, 2 and 0, like the flags.
// - Both flag registers are read-only at offsets 1 and 2, reset to zero, reserved bits read zero.
// - The first mask register sits at offset 3, resets to zero, bits 7 and 6 read-only zero, rest writable.
// - The second mask register holds the switch overheat mask at bit 5 and current-limit mask at bit 2.
// - A status register shows the live mains-detect level, 1 while the input is driven low.
`default_nettype none
module pef_event_flags
    import pef_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = pef_pkg::I2C_ADDR_DFLT,
    parameter logic [4:0] PART_CODE = pef_pkg::PART_CODE_DFLT,
    parameter logic [2:0] ISSUE     = pef_pkg::ISSUE_DFLT
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire pef_pkg::pef_pins_t pins,
    output var  logic               sda_o,
    output var  logic               sda_oe,
    output var  logic               irq_n_pin
);

    import pef_pkg::*;

    pef_pins_t      s;
    pef_reg_req_t   req;
    pef_i2c_state_t st;
    pef_i2c_state_t next_st;
    logic [7:0]     rd_data;
    logic [7:0]     latch_a;
    logic [7:0]     latch_b;
    logic [7:0]     mask_a;
    logic [7:0]     mask_b;
    logic [7:0]     next_latch_a;
    logic [7:0]     next_latch_b;
    logic [7:0]     next_mask_a;
    logic [7:0]     next_mask_b;
    logic [7:0]     set_a;
    logic [7:0]     set_b;
    logic [7:0]     flags_a;
    logic [7:0]     flags_b;
    logic [7:0]     status;
    logic           prev_mains;
    logic           prev_pb;
    logic           prev_done;
    logic           next_irq_n;
    logic           scl_prev;
    logic           sda_prev;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_seen;
    logic           stop_seen;
    logic [3:0]     bit_cnt;
    logic [3:0]     next_bit_cnt;
    logic [7:0]     shreg;
    logic [7:0]     next_shreg;
    logic [7:0]     ptr;
    logic [7:0]     next_ptr;
    logic           first_byte;
    logic           next_first_byte;
    logic           next_sda_oe;

    // Every pin, bus lines included, crosses in here first
    pef_sync #(
        .WIDTH   (PINS_W),
        .RST_VAL (PINS_IDLE)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins),
        .sync_out (s)
    );

    // Event detection
    always_comb begin
        set_a = 8'h00;
        set_b = 8'h00;
        set_a[BIT_LOW_SUPPLY]  = s.low_supply;
        set_a[BIT_MAINS]       = s.mains_detect_input ^ prev_mains;
        set_a[BIT_PUSH_BUTTON] = s.push_button_input ^ prev_pb;
        set_a[BIT_STORE_DONE]  = s.store_done & ~prev_done;
        set_b[BIT_SW_OVERHEAT] = s.switch_overheat;
    end

    // Level-type bits read live so they drop as soon as the cause goes
    always_comb begin
        flags_a = latch_a;
        flags_b = latch_b;
        flags_a[BIT_OVERHEAT]   = s.overheat;
        flags_b[BIT_SW_CUR_LIM] = s.switch_current_limit;
        flags_a = flags_a & FLAGS_A_USED;
        flags_b = flags_b & FLAGS_B_USED;
    end

    // Latched flags: a set in the clearing cycle survives the clear
    always_comb begin
        next_latch_a = latch_a;
        next_latch_b = latch_b;
        if (req.rd && req.addr == OFS_FLAGS_A) begin
            next_latch_a = FLAGS_RST;
        end
        if (req.rd && req.addr == OFS_FLAGS_B) begin
            next_latch_b = FLAGS_RST;
        end
        next_latch_a = next_latch_a | set_a;
        next_latch_b = next_latch_b | set_b;
    end

    // Mask writes, upper two bits stay zero
    always_comb begin
        next_mask_a = mask_a;
        next_mask_b = mask_b;
        if (req.wr && req.addr == OFS_MASK_A) begin
            next_mask_a = req.data & MASK_WRITABLE;
        end
        if (req.wr && req.addr == OFS_MASK_B) begin
            next_mask_b = req.data & MASK_WRITABLE;
        end
    end

    // Pin low while any unmasked flag stands
    always_comb begin
        next_irq_n = ~(|(flags_a & ~mask_a) | |(flags_b & ~mask_b));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_a    <= FLAGS_RST;
            latch_b    <= FLAGS_RST;
            mask_a     <= MASK_RST;
            mask_b     <= MASK_RST;
            prev_mains <= 1'b1;
            prev_pb    <= 1'b1;
            prev_done  <= 1'b0;
            irq_n_pin  <= 1'b1;
        end else begin
            latch_a    <= next_latch_a;
            latch_b    <= next_latch_b;
            mask_a     <= next_mask_a;
            mask_b     <= next_mask_b;
            prev_mains <= s.mains_detect_input;
            prev_pb    <= s.push_button_input;
            prev_done  <= s.store_done;
            irq_n_pin  <= next_irq_n;
        end
    end

    // Read mux; unknown offsets read zero
    always_comb begin
        status = 8'h00;
        status[BIT_MAINS_LEVEL] = ~s.mains_detect_input;
        case (ptr)
            OFS_PART_ID: rd_data = {PART_CODE, ISSUE};
            OFS_FLAGS_A: rd_data = flags_a;
            OFS_FLAGS_B: rd_data = flags_b;
            OFS_MASK_A:  rd_data = mask_a;
            OFS_MASK_B:  rd_data = mask_b;
            OFS_STATUS:  rd_data = status;
            default:     rd_data = 8'h00;
        endcase
    end

    // Serial slave: bus edges from synchronised lines
    always_comb begin
        scl_rise   = s.scl & ~scl_prev;
        scl_fall   = ~s.scl & scl_prev;
        start_seen = s.scl & scl_prev & sda_prev & ~s.sda;
        stop_seen  = s.scl & scl_prev & ~sda_prev & s.sda;
    end

    // No unlock step: every pointer write and data write goes straight through
    always_comb begin
        next_st         = st;
        next_bit_cnt    = bit_cnt;
        next_shreg      = shreg;
        next_ptr        = ptr;
        next_first_byte = first_byte;
        next_sda_oe     = sda_oe;
        req.rd          = 1'b0;
        req.wr          = 1'b0;
        req.addr        = ptr;
        req.data        = shreg;
        if (stop_seen) begin
            next_st     = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_seen) begin
            next_st         = ST_ADDR;
            next_bit_cnt    = 4'h0;
            next_first_byte = 1'b1;
            next_sda_oe     = 1'b0;
        end else begin
            case (st)
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        next_shreg   = {shreg[6:0], s.sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        if (st == ST_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                next_sda_oe = 1'b1;
                                next_st     = ST_ADDR_ACK;
                            end else begin
                                next_st = ST_IDLE;
                            end
                        end else begin
                            next_sda_oe = 1'b1;
                            next_st     = ST_WR_ACK;
                            if (first_byte) begin
                                next_ptr        = shreg;
                                next_first_byte = 1'b0;
                            end else begin
                                req.wr   = 1'b1;
                                next_ptr = ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (st == ST_ADDR_ACK && shreg[0]) begin
                            req.rd      = 1'b1;
                            next_shreg  = rd_data;
                            next_sda_oe = ~rd_data[7];
                            next_ptr    = ptr + 8'h01;
                            next_st     = ST_RD_BYTE;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_st     = ST_WR_BYTE;
                        end
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                            next_sda_oe = 1'b0;
                            next_st     = ST_RD_ACK;
                        end else begin
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    // A not-acknowledge ends the burst; wait for stop or start
                    if (scl_rise && s.sda) begin
                        next_st = ST_IDLE;
                    end else if (scl_fall) begin
                        req.rd       = 1'b1;
                        next_shreg   = rd_data;
                        next_sda_oe  = ~rd_data[7];
                        next_ptr     = ptr + 8'h01;
                        next_bit_cnt = 4'h0;
                        next_st      = ST_RD_BYTE;
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            first_byte <= 1'b1;
            sda_oe     <= 1'b0;
            scl_prev   <= 1'b1;
            sda_prev   <= 1'b1;
        end else begin
            st         <= next_st;
            bit_cnt    <= next_bit_cnt;
            shreg      <= next_shreg;
            ptr        <= next_ptr;
            first_byte <= next_first_byte;
            sda_oe     <= next_sda_oe;
            scl_prev   <= s.scl;
            sda_prev   <= s.sda;
        end
    end

    // Open drain: only ever pulls low
    always_comb begin
        sda_o = 1'b0;
    end

endmodule
`default_nettype wire

// file: shared/pef_pkg.sv
// Shared constants and types for the event flag and mask block
`default_nettype none
package pef_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PART_ID  = 8'h00;
    localparam logic [7:0] OFS_FLAGS_A  = 8'h01;
    localparam logic [7:0] OFS_FLAGS_B  = 8'h02;
    localparam logic [7:0] OFS_MASK_A   = 8'h03;
    localparam logic [7:0] OFS_MASK_B   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h05;

    // Field positions, flags and masks share them
    localparam int BIT_LOW_SUPPLY  = 5;
    localparam int BIT_MAINS       = 4;
    localparam int BIT_PUSH_BUTTON = 3;
    localparam int BIT_OVERHEAT    = 2;
    localparam int BIT_STORE_DONE  = 0;
    localparam int BIT_SW_OVERHEAT = 5;
    localparam int BIT_SW_CUR_LIM  = 2;
    localparam int BIT_MAINS_LEVEL = 5;
    localparam int PART_CODE_LSB   = 3;

    // Reset values and bit groups
    localparam logic [7:0] FLAGS_RST      = 8'h00;
    localparam logic [7:0] MASK_RST       = 8'h00;
    localparam logic [7:0] MASK_WRITABLE  = 8'h3f;
    localparam logic [7:0] FLAGS_A_USED   = 8'h3d;
    localparam logic [7:0] FLAGS_B_USED   = 8'h24;

    // Identity and bus address defaults, values arbitrary
    localparam logic [4:0] PART_CODE_DFLT = 5'h0c;
    localparam logic [2:0] ISSUE_DFLT     = 3'h3;
    localparam logic [6:0] I2C_ADDR_DFLT  = 7'h4a;

    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // Raw pin group, all asynchronous to clk
    typedef struct packed {
        logic scl;
        logic sda;
        logic mains_detect_input;
        logic push_button_input;
        logic low_supply;
        logic overheat;
        logic store_done;
        logic switch_overheat;
        logic switch_current_limit;
    } pef_pins_t;

    localparam int PINS_W = $bits(pef_pins_t);

    // Idle levels: bus lines and active-low pins high
    localparam pef_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, mains_detect_input: 1'b1,
                                        push_button_input: 1'b1, default: 1'b0};

    // Register access strobe from the serial engine
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } pef_reg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } pef_i2c_state_t;

endpackage
`default_nettype wire

// file: rtl/pef_sync.sv
// Two-flop synchroniser bank for asynchronous pins
`default_nettype none
module pef_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            logic next_stage1;
            logic next_stage2;

            // One flop per bit owns its output bit, no shared writers
            assign sync_out[i] = stage2;

            always_comb begin
                next_stage1 = async_in[i];
                next_stage2 = stage1;
            end

            // First stage feeds only the second
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1 <= RST_VAL[i];
                    stage2 <= RST_VAL[i];
                end else begin
                    stage1 <= next_stage1;
                    stage2 <= next_stage2;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: dv/pef_event_flags_assertions.sv
// Port-level checks for the event flag block
`default_nettype none
module pef_event_flags_assertions
    import pef_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire pef_pkg::pef_pins_t pins,
    input  wire logic               sda_o,
    input  wire logic               sda_oe,
    input  wire logic               irq_n_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since any pin moved; irq may only follow a cause
    pef_pins_t  prev_pins;
    logic [3:0] quiet;
    logic [3:0] next_quiet;

    always_comb begin
        next_quiet = (pins != prev_pins) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_pins <= PINS_IDLE;
            quiet     <= 4'h0;
        end else begin
            prev_pins <= pins;
            quiet     <= next_quiet;
        end
    end

    sequence idle_out;
        irq_n_pin && !sda_oe;
    endsequence

    sequence scl_low_2;
        !$past(pins.scl) && !$past(pins.scl, 2);
    endsequence

    AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data output not held low");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> idle_out ##1 idle_out)
        else $error("outputs not idle after reset");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !pins.scl)
        else $error("data drive changed while clock high");
    AST_OE_LATENCY: assert property ($fell(pins.scl) |-> $stable(sda_oe)[*2])
        else $error("data drive changed too soon after clock fall");
    AST_IRQ_CAUSE: assert property ($changed(irq_n_pin) |-> quiet < 4'h8)
        else $error("interrupt pin moved without a cause");
    AST_OE_SCL_HIGH: assert property (pins.scl [*2] |-> $stable(sda_oe))
        else $error("data drive moved during clock high");
    AST_OE_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("data drive released too early");
    AST_OE_AFTER_LOW: assert property ($changed(sda_oe) |-> scl_low_2)
        else $error("data drive changed before clock was low");
endmodule
`default_nettype wire

// file: dv/pef_host_model.sv
// Host two-wire master model for register access
`default_nettype none
module pef_host_model
    import pef_pkg::*;
#(
    parameter logic [6:0] ADDR = pef_pkg::I2C_ADDR_DFLT
) (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_m
);
    timeunit 1ns;
    timeprecision 1ns;

    // Set when the device fails to acknowledge a host byte
    logic nak = 1'b0;

    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // SDA moves 2 clk after SCL fall so the device never sees it as a start or stop
    task automatic bit_x(input logic b, output logic r);
        hold(2);
        sda_m <= b;
        hold(8);
        scl <= 1'b1;
        hold(5);
        r = sda;
        hold(5);
        scl <= 1'b0;
    endtask

    task automatic frame(input logic s);
        hold(2);
        sda_m <= s;
        hold(8);
        scl <= 1'b1;
        hold(10);
        sda_m <= !s;
        hold(10);
        if (s) scl <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic send, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(1'b1, a);
        if (send) nak |= a;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] x;
        frame(1'b1);
        xfer({ADDR, 1'b0}, 1'b1, x);
        xfer(ofs, 1'b1, x);
        xfer(d, 1'b1, x);
        frame(1'b0);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
        logic [7:0] x;
        frame(1'b1);
        xfer({ADDR, 1'b0}, 1'b1, x);
        xfer(ofs, 1'b1, x);
        frame(1'b1);
        xfer({ADDR, 1'b1}, 1'b1, x);
        xfer(8'hff, 1'b0, q);
        frame(1'b0);
    endtask
endmodule
`default_nettype wire

// file: dv/pef_event_flags_tb_top.sv
// Self-checking bench for the event flag and mask block
`default_nettype none
module pef_event_flags_tb_top
    import pef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [6:0] ev = 7'h60;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe;
    logic       irq_n_pin;
    pef_pins_t  pins;
    logic [7:0] q;
    logic [7:0] m;
    logic [7:0] ofs;
    logic [7:0] bitv;
    int         n_errors = 0;
    int         samples_checked = 0;
    // Flag position and level left after the cause goes, per event
    int         fbit[7] = '{4, 3, 5, 2, 0, 5, 2};
    int         after[7] = '{1, 1, 1, 0, 0, 1, 0};

    always #50 clk = ~clk;

    // Pulled-up data wire
    assign pins = {scl, sda_m & ~sda_oe, ev};

    pef_event_flags dut (.clk(clk), .rst_n(rst_n), .pins(pins), .sda_o(sda_o), .sda_oe(sda_oe),
                         .irq_n_pin(irq_n_pin));
    pef_host_model host (.clk(clk), .sda(pins.sda), .scl(scl), .sda_m(sda_m));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, q);
        chk(q, exp);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(5072));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({7'h0, irq_n_pin}, 8'h01);
        rd_chk(OFS_PART_ID, {PART_CODE_DFLT, ISSUE_DFLT});
        for (int a = 1; a < 7; a++) rd_chk(a[7:0], 8'h00);
        $display("reset test done");
        host.wr(OFS_MASK_A, 8'hff);
        rd_chk(OFS_MASK_A, 8'h3f);
        host.wr(OFS_FLAGS_A, 8'hff);
        rd_chk(OFS_FLAGS_A, 8'h00);
        $display("access test done");
        for (int i = 0; i < 7; i++) begin
            ofs = (i < 5) ? OFS_FLAGS_A : OFS_FLAGS_B;
            m = 8'($urandom) & MASK_WRITABLE;
            host.wr(ofs + 8'h02, m);
            rd_chk(ofs + 8'h02, m);
            bitv = 8'h01 << fbit[i];
            ev[6-i] <= ~ev[6-i];
            repeat (10) @(posedge clk);
            chk({7'h0, irq_n_pin}, {7'h0, (bitv & ~m) == 8'h00});
            rd_chk(ofs, bitv);
            if (i == 0) rd_chk(OFS_STATUS, 8'h20);
            ev[6-i] <= ~ev[6-i];
            repeat (10) @(posedge clk);
            rd_chk(ofs, (after[i] != 0) ? bitv : 8'h00);
            rd_chk(ofs, 8'h00);
            chk({7'h0, irq_n_pin}, 8'h01);
            $display("event test %0d done", i);
        end
        chk({7'h0, host.nak}, 8'h00);
        stop_test();
    end
endmodule

bind pef_event_flags pef_event_flags_assertions u_chk (.clk(clk), .rst_n(rst_n), .pins(pins), .sda_o(sda_o),
                                                       .sda_oe(sda_oe), .irq_n_pin(irq_n_pin));
`default_nettype wire
